// ### common/pim_defs.vh
// Constants shared by the process image byte mapper and its helpers.
`ifndef PIM_DEFS_VH
`define PIM_DEFS_VH

// ----------------------------------------------------------------------------
// Image geometry
// ----------------------------------------------------------------------------
`define PIM_CHANNELS 4
`define PIM_BYTE_W 8
`define PIM_WORD_W 16
`define PIM_VALUE_W 16
`define PIM_MAX_WORDS 8
`define PIM_IDX_W 3
`define PIM_CNT_W 4
`define PIM_POS_W 4
`define PIM_FIFO_DEPTH 16

// ----------------------------------------------------------------------------
// Coupler variants
// ----------------------------------------------------------------------------
`define PIM_VAR_W 2
`define PIM_VAR_STD 2'h0
`define PIM_VAR_OPT_RING 2'h1
`define PIM_VAR_RING_BUS 2'h2

// ----------------------------------------------------------------------------
// Transfer states
// ----------------------------------------------------------------------------
`define PIM_ST_W 1
`define PIM_ST_IDLE 1'h0
`define PIM_ST_SEND 1'h1

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PIM_ZERO_BYTE 8'h00
`define PIM_ZERO_WORD 16'h0000

`endif

// ### tb/fb_master_model.sv
// Fieldbus master model that takes input image words with gaps or stalls.
`timescale 1ns/1ps
module fb_master_model (
  input wire sys_clk_in, // System clock
  input wire rstn_in, // Reset, active low
  input wire stall_in, // Hold off all words
  output logic ready_out = 1'b0 // Takes the head word
);
  // Random gaps mimic a master busy with its own bus cycle.
  always @(posedge sys_clk_in) begin
    if (!rstn_in || stall_in) begin
      ready_out <= 1'b0;
    end else begin
      ready_out <= ($urandom % 4) != 0;
    end
  end
endmodule // fb_master_model

// ### tb/pim_properties.sv
// Port-level checks for the process image byte mapper.
`timescale 1ns/1ps
module pim_properties #(
  parameter NCH = 4
) (
  input wire sys_clk_in, // Clock
  input wire rstn_in, // Reset, active low
  input wire complete_eval_in, // Evaluation
  input wire word_align_in, // Alignment
  input wire [NCH-1:0] cs_mask_in, // Status mask
  input wire [1:0] variant_in, // Variant
  input wire xfer_req_in, // Request
  input wire xfer_busy_out, // Busy
  input wire [3:0] img_words_out, // Word count
  input wire fb_out_wr_in, // Fieldbus write
  input wire [2:0] fb_out_idx_in, // Fieldbus index
  input wire [15:0] fb_out_word_in, // Fieldbus data
  input wire cfg_out_wr_in, // Config write
  input wire cfg_out_refused_out, // Config refused
  input wire [NCH*8-1:0] channel_control_byte_out, // Control bytes
  input wire [NCH-1:0] ctrl_valid_out // Control valid
);
  wire std_idle = variant_in == 2'h0 && !xfer_busy_out;
  wire lay_plain = std_idle && !complete_eval_in;
  wire lay_full = std_idle && complete_eval_in && cs_mask_in == {NCH{1'b1}};
  wire lay_unal = lay_full && !word_align_in;

  default clocking dc @(posedge sys_clk_in);
  endclocking
  default disable iff (!rstn_in);

  property p_busy_start;
    !xfer_busy_out && xfer_req_in |=> xfer_busy_out;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("request not taken");
  property p_words_plain;
    lay_plain [*4] |-> img_words_out == 4'h4;
  endproperty
  a_words_plain: assert property (p_words_plain) else $error("plain size wrong");
  property p_words_unal;
    lay_unal [*4] |-> img_words_out == 4'h6;
  endproperty
  a_words_unal: assert property (p_words_unal) else $error("packed size wrong");
  property p_words_al;
    (lay_full && word_align_in) [*4] |-> img_words_out == 4'h8;
  endproperty
  a_words_al: assert property (p_words_al) else $error("aligned size wrong");
  property p_words_opt;
    (variant_in == 2'h1 && !xfer_busy_out) [*4] |-> img_words_out == 4'h8;
  endproperty
  a_words_opt: assert property (p_words_opt) else $error("ring size wrong");
  property p_words_nomask;
    (std_idle && complete_eval_in && cs_mask_in == '0) [*4] |-> img_words_out == 4'h4;
  endproperty
  a_words_nomask: assert property (p_words_nomask) else $error("mask ignored");
  property p_refused;
    1'b1 |=> cfg_out_refused_out == $past(fb_out_wr_in && cfg_out_wr_in);
  endproperty
  a_refused: assert property (p_refused) else $error("refusal flag wrong");
  property p_ctrl_map;
    (lay_unal && fb_out_wr_in && fb_out_idx_in == 3'h0 && !cfg_out_wr_in)
      ##1 (lay_unal && !fb_out_wr_in && !cfg_out_wr_in)
      |=> channel_control_byte_out[7:0] == $past(fb_out_word_in[7:0], 2) && ctrl_valid_out[0];
  endproperty
  a_ctrl_map: assert property (p_ctrl_map) else $error("control byte wrong");
  property p_ctrl_off;
    lay_plain [*4] |-> ctrl_valid_out == '0 && channel_control_byte_out == '0;
  endproperty
  a_ctrl_off: assert property (p_ctrl_off) else $error("control byte unmapped");

  c_req: cover property (xfer_req_in && !xfer_busy_out);
  c_clash: cover property (fb_out_wr_in && cfg_out_wr_in);
  c_full: cover property (xfer_busy_out [*8]);
endmodule // pim_properties

// ### tb/tb_process_image_byte_mapper.sv
// Self-checking bench for the process image byte mapper.
`timescale 1ns/1ps
module tb_process_image_byte_mapper;
  logic sys_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic ce = 1'b0, be = 1'b0, al = 1'b0, req = 1'b0, stall = 1'b0, mw = 1'b0;
  logic fbw = 1'b0, cw = 1'b0, rimg = 1'b0;
  logic [3:0] mask = 4'h0, rmask = 4'h0;
  logic [1:0] vsel = 2'h0;
  logic [63:0] vals = 64'h0;
  logic [31:0] sts = 32'h0;
  logic [2:0] fbi = 3'h0, ci = 3'h0, ridx = 3'h0;
  logic [15:0] fbd = 16'h0, cd = 16'h0;
  logic [15:0] img[8];
  logic [15:0] expq[$];
  wire rdy, busy, ival, refused;
  wire [3:0] nwords, cval;
  wire [15:0] iword, rdata;
  wire [31:0] ctrl;
  int nimg;
  int fails = 0;
  int num_checks = 0;

  always #2 sys_clk_in = ~sys_clk_in;

  process_image_byte_mapper #(.NCH(4), .FIFO_DEPTH(16)) uut (
    .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .complete_eval_in(ce), .big_endian_in(be),
    .word_align_in(al), .cs_mask_in(mask), .variant_in(vsel), .chan_value_in(vals),
    .channel_status_byte_in(sts), .xfer_req_in(req), .xfer_busy_out(busy),
    .img_words_out(nwords), .in_word_out(iword), .in_valid_out(ival), .in_ready_in(rdy),
    .fb_out_wr_in(fbw), .fb_out_idx_in(fbi), .fb_out_word_in(fbd), .cfg_mask_wr_in(mw),
    .cfg_mask_in(rmask), .cfg_out_wr_in(cw), .cfg_out_idx_in(ci), .cfg_out_word_in(cd),
    .cfg_out_refused_out(refused), .cfg_rd_img_in(rimg), .cfg_rd_idx_in(ridx),
    .cfg_rd_data_out(rdata), .channel_control_byte_out(ctrl), .ctrl_valid_out(cval));

  fb_master_model fbm (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .stall_in(stall),
    .ready_out(rdy));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    if (fails == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Expected image from the layout inputs
  // ------------------------------------------------------------------
  function automatic void build();
    logic [7:0] b[16];
    logic [3:0] inc;
    logic a;
    int p;
    p = 0;
    a = al || vsel == 2'h1;
    inc = vsel == 2'h1 ? 4'hf : vsel == 2'h2 ? rmask : !ce ? 4'h0 : mask;
    foreach (b[i]) b[i] = 8'h00;
    for (int c = 0; c < 4; c++) begin
      if (a) p += p % 2;
      if (inc[c]) begin
        b[p] = sts[8*c +: 8];
        p += a ? 2 : 1;
      end
      b[p] = be ? vals[16*c+8 +: 8] : vals[16*c +: 8];
      b[p+1] = be ? vals[16*c +: 8] : vals[16*c+8 +: 8];
      p += 2;
    end
    nimg = (p + 1) / 2;
    for (int k = 0; k < 8; k++) img[k] = {b[2*k+1], b[2*k]};
  endfunction

  task automatic start_xfer();
    repeat (3) @(posedge sys_clk_in);
    #1;
    build();
    chk("img_words", 16'(nimg), {12'h0, nwords});
    for (int k = 0; k < nimg; k++) expq.push_back(img[k]);
    @(posedge sys_clk_in);
    req <= 1'b1;
    @(posedge sys_clk_in);
    req <= 1'b0;
  endtask

  task automatic wait_idle();
    int i;
    i = 0;
    do begin
      @(posedge sys_clk_in);
      #1;
      i++;
    end while (busy !== 1'b0 && i < 200);
    chk("busy_end", 16'h0, {15'h0, busy});
  endtask

  task automatic drain();
    for (int i = 0; i < 100 && expq.size() != 0; i++) @(posedge sys_clk_in);
    repeat (2) @(posedge sys_clk_in);
    #1;
    chk("words_left", 16'h0, 16'(expq.size()));
    chk("in_valid", 16'h0, {15'h0, ival});
  endtask

  always @(posedge sys_clk_in) begin
    if (rstn_in && ival === 1'b1 && rdy === 1'b1) begin
      if (expq.size() == 0) begin
        fails++;
        $display("BAD in_word expected none seen %h", iword);
      end else begin
        chk("in_word", expq.pop_front(), iword);
      end
    end
  end

  initial begin
    #200000;
    fails++;
    summarize();
  end

  initial begin
    void'($urandom(32'heb1ff0e7));
    repeat (8) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    @(posedge sys_clk_in);
    rmask <= 4'h5;
    mw <= 1'b1;
    for (int m = 0; m < 19; m++) begin
      @(posedge sys_clk_in);
      mw <= 1'b0;
      ce <= m[2] | m[4];
      be <= m[1];
      al <= m[0];
      vsel <= m < 16 ? 2'h0 : 2'(m - 15);
      mask <= m == 12 ? 4'h0 : m < 8 ? 4'hf : 4'($urandom);
      vals <= {$urandom, $urandom};
      sts <= $urandom;
      start_xfer();
      wait_idle();
    end
    drain();
    // A stalled master lets two aligned images fill the buffer; the third must wait.
    @(posedge sys_clk_in);
    {vsel, ce, al, be, mask, stall} <= {2'h0, 3'h6, 4'hf, 1'b1};
    repeat (2) begin
      start_xfer();
      wait_idle();
    end
    start_xfer();
    repeat (20) @(posedge sys_clk_in);
    #1 chk("busy_full", 16'h1, {15'h0, busy});
    @(posedge sys_clk_in);
    stall <= 1'b0;
    wait_idle();
    drain();
    @(posedge sys_clk_in);
    al <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      repeat (3) @(posedge sys_clk_in);
      fbw <= 1'b1;
      fbi <= 3'((3 * c) / 2);
      fbd <= 16'($urandom);
      @(posedge sys_clk_in);
      fbw <= 1'b0;
      rimg <= 1'b1;
      ridx <= fbi;
      repeat (2) @(posedge sys_clk_in);
      #1 chk("ctrl", {8'h0, c % 2 ? fbd[15:8] : fbd[7:0]}, {8'h0, ctrl[8*c +: 8]});
      chk("ctrl_valid", 16'h1, {15'h0, cval[c]});
      chk("mon_out", fbd, rdata);
    end
    @(posedge sys_clk_in);
    {fbw, cw, fbi, ci, fbd, cd} <= {2'h3, 6'h0, 32'h12345678};
    @(posedge sys_clk_in);
    {fbw, cw, ridx} <= 5'h0;
    #1 chk("refused", 16'h1, {15'h0, refused});
    @(posedge sys_clk_in);
    #1 chk("mon_clash", 16'h1234, rdata);
    @(posedge sys_clk_in);
    cw <= 1'b1;
    cd <= 16'h9abc;
    @(posedge sys_clk_in);
    cw <= 1'b0;
    #1 chk("refused", 16'h0, {15'h0, refused});
    @(posedge sys_clk_in);
    #1 chk("mon_cfg", 16'h9abc, rdata);
    @(posedge sys_clk_in);
    rimg <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    #1 chk("mon_in", img[0], rdata);
    summarize();
  end
endmodule // tb_process_image_byte_mapper

bind process_image_byte_mapper pim_properties #(.NCH(NCH)) u_props (
  .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .complete_eval_in(complete_eval_in),
  .word_align_in(word_align_in), .cs_mask_in(cs_mask_in), .variant_in(variant_in),
  .xfer_req_in(xfer_req_in), .xfer_busy_out(xfer_busy_out), .img_words_out(img_words_out),
  .fb_out_wr_in(fb_out_wr_in), .fb_out_idx_in(fb_out_idx_in), .fb_out_word_in(fb_out_word_in),
  .cfg_out_wr_in(cfg_out_wr_in), .cfg_out_refused_out(cfg_out_refused_out),
  .channel_control_byte_out(channel_control_byte_out), .ctrl_valid_out(ctrl_valid_out));

// ### verilog/pim_chan_bytes.v
// Orders the two data bytes of one channel value for the selected byte order.
`timescale 1ns/1ps
`include "pim_defs.vh"

module pim_chan_bytes #(
  parameter VALUE_W = `PIM_VALUE_W
) (
  input wire [VALUE_W-1:0] chan_value_in, // Channel value, low byte in bits 7:0
  input wire big_endian_in,               // High when big-endian order is selected
  output wire [7:0] first_byte_out,       // Byte placed at the lower image position
  output wire [7:0] second_byte_out       // Byte placed at the next image position
);

  wire [7:0] data_low_byte;
  wire [7:0] data_high_byte;

  assign data_low_byte = chan_value_in[7:0];
  assign data_high_byte = chan_value_in[15:8];

  // Lower image position is the lower half of a word in the default layout.
  assign first_byte_out = big_endian_in ? data_high_byte : data_low_byte;
  assign second_byte_out = big_endian_in ? data_low_byte : data_high_byte;

endmodule // pim_chan_bytes

// ### verilog/pim_fifo.v
// Synchronous FIFO with valid/ready on both sides for the input image stream.
`timescale 1ns/1ps
`include "pim_defs.vh"

module pim_fifo #(
  parameter WIDTH = `PIM_WORD_W,
  parameter DEPTH = `PIM_FIFO_DEPTH,
  parameter AW = 4
) (
  input wire sys_clk_in,             // System clock
  input wire rstn_in,                // Synchronous reset, active low
  input wire [WIDTH-1:0] wr_data_in, // Write data
  input wire wr_valid_in,            // Write request
  output wire wr_ready_out,          // Space available
  output wire [WIDTH-1:0] rd_data_out, // Head word
  output wire rd_valid_out,          // Head word valid
  input wire rd_ready_in             // Drain side takes head word
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr_r;
  reg [AW:0] rd_ptr_r;
  wire full;
  wire empty;
  wire do_wr;
  wire do_rd;

  assign empty = (wr_ptr_r == rd_ptr_r);
  assign full = (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]) && (wr_ptr_r[AW] != rd_ptr_r[AW]);
  assign wr_ready_out = ~full;
  assign rd_valid_out = ~empty;
  assign rd_data_out = mem[rd_ptr_r[AW-1:0]];
  assign do_wr = wr_valid_in & ~full;
  assign do_rd = rd_ready_in & ~empty;

  always @(posedge sys_clk_in) begin
    if (do_wr) begin
      mem[wr_ptr_r[AW-1:0]] <= wr_data_in;
    end
  end

  always @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      wr_ptr_r <= {(AW+1){1'b0}};
      rd_ptr_r <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

endmodule // pim_fifo

// ### verilog/process_image_byte_mapper.v
// Maps four channel values and their control/status bytes into a word process image.
`timescale 1ns/1ps
`include "pim_defs.vh"

module process_image_byte_mapper #(
  parameter NCH = `PIM_CHANNELS,
  parameter FIFO_DEPTH = `PIM_FIFO_DEPTH
) (
  input wire sys_clk_in,                       // 250 MHz system clock
  input wire rstn_in,                          // Synchronous reset, active low
  input wire complete_eval_in,                 // Map control/status bytes
  input wire big_endian_in,                    // Big-endian data byte order
  input wire word_align_in,                    // Place channels on word boundaries
  input wire [NCH-1:0] cs_mask_in,             // Per-channel status byte selection
  input wire [1:0] variant_in,                 // Coupler variant code
  input wire [NCH*16-1:0] chan_value_in,       // Channel values, channel 0 lowest
  input wire [NCH*8-1:0] channel_status_byte_in, // Status bytes, channel 0 lowest
  input wire xfer_req_in,                      // Start one input image transfer
  output wire xfer_busy_out,                   // Transfer in progress
  output wire [3:0] img_words_out,             // Words in current layout
  output wire [15:0] in_word_out,              // Input image word to fieldbus
  output wire in_valid_out,                    // Input image word valid
  input wire in_ready_in,                      // Fieldbus takes input image word
  input wire fb_out_wr_in,                     // Fieldbus writes an output image word
  input wire [2:0] fb_out_idx_in,              // Output image word index
  input wire [15:0] fb_out_word_in,            // Output image word data
  input wire cfg_mask_wr_in,                   // Config port writes ring bus mask
  input wire [NCH-1:0] cfg_mask_in,            // Ring bus status byte mask
  input wire cfg_out_wr_in,                    // Config port writes output image
  input wire [2:0] cfg_out_idx_in,             // Config port write index
  input wire [15:0] cfg_out_word_in,           // Config port write data
  output wire cfg_out_refused_out,             // Config write lost to fieldbus
  input wire cfg_rd_img_in,                    // Monitor select: 0 input, 1 output
  input wire [2:0] cfg_rd_idx_in,              // Monitor word index
  output wire [15:0] cfg_rd_data_out,          // Monitor read data
  output wire [NCH*8-1:0] channel_control_byte_out, // Decoded control bytes
  output wire [NCH-1:0] ctrl_valid_out         // Control byte mapped for channel
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  localparam IMG_BITS = `PIM_MAX_WORDS * `PIM_WORD_W;

  reg [`PIM_ST_W-1:0] state_r;
  reg complete_eval_r;
  reg big_endian_r;
  reg word_align_r;
  reg [NCH-1:0] cs_mask_r;
  reg [`PIM_VAR_W-1:0] variant_r;
  reg [NCH-1:0] ring_mask_r;
  reg [IMG_BITS-1:0] in_img_r;
  reg [IMG_BITS-1:0] img_nxt;
  reg [NCH*`PIM_POS_W-1:0] cs_pos_nxt;
  reg [NCH*`PIM_POS_W-1:0] cs_pos_r;
  reg [NCH-1:0] incl_nxt;
  reg [NCH-1:0] incl_r;
  reg [`PIM_CNT_W-1:0] words_nxt;
  reg [`PIM_CNT_W-1:0] words_r;
  reg [`PIM_CNT_W-1:0] send_idx_r;
  reg [15:0] out_img_r [0:`PIM_MAX_WORDS-1];
  reg [15:0] cfg_rd_data_r;
  reg cfg_out_refused_r;
  reg [NCH*8-1:0] ctrl_byte_r;
  reg [NCH*8-1:0] ctrl_byte_nxt;
  reg [NCH-1:0] ctrl_valid_r;
  reg eff_align;
  reg [NCH-1:0] eff_incl;
  wire [NCH*8-1:0] first_bytes;
  wire [NCH*8-1:0] second_bytes;
  wire fifo_wr_ready;
  wire fifo_push;
  wire [15:0] send_word;
  integer pos;
  integer c;
  integer k;
  integer w;

  // --------------------------------------------------------------------------
  // Layout sampling
  // --------------------------------------------------------------------------
  // The layout may only change between transfers, so a fieldbus frame never
  // sees half of one layout and half of another.
  always @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      complete_eval_r <= 1'b0;
      big_endian_r <= 1'b0;
      word_align_r <= 1'b0;
      cs_mask_r <= {NCH{1'b0}};
      variant_r <= `PIM_VAR_STD;
    end else if (state_r == `PIM_ST_IDLE) begin
      complete_eval_r <= complete_eval_in;
      big_endian_r <= big_endian_in;
      word_align_r <= word_align_in;
      cs_mask_r <= cs_mask_in;
      variant_r <= variant_in;
    end
  end

  // The ring bus variant has no parameter path over the fieldbus; its status
  // byte selection comes only from the configuration port.
  always @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      ring_mask_r <= {NCH{1'b0}};
    end else if (cfg_mask_wr_in) begin
      ring_mask_r <= cfg_mask_in;
    end
  end

  always @* begin
    eff_align = word_align_r;
    eff_incl = complete_eval_r ? cs_mask_r : {NCH{1'b0}};
    case (variant_r)
      `PIM_VAR_OPT_RING: begin
        eff_align = 1'b1;
        eff_incl = {NCH{1'b1}};
      end
      `PIM_VAR_RING_BUS: begin
        eff_incl = ring_mask_r;
      end
      default: begin
        eff_align = word_align_r;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Byte ordering per channel
  // --------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_chan
      pim_chan_bytes #(
        .VALUE_W(`PIM_VALUE_W)
      ) u_bytes (
        .chan_value_in(chan_value_in[g*16 +: 16]),
        .big_endian_in(big_endian_r),
        .first_byte_out(first_bytes[g*8 +: 8]),
        .second_byte_out(second_bytes[g*8 +: 8])
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Image layout builder
  // --------------------------------------------------------------------------
  // Bytes fill the low half of a word before the high half. Alignment rounds
  // the byte position up to the next word before each channel group.
  always @* begin
    img_nxt = {IMG_BITS{1'b0}};
    cs_pos_nxt = {(NCH*`PIM_POS_W){1'b0}};
    incl_nxt = eff_incl;
    pos = 0;
    for (c = 0; c < NCH; c = c + 1) begin
      if (eff_align) begin
        pos = pos + (pos % 2);
      end
      if (eff_incl[c]) begin
        img_nxt[pos*8 +: 8] = channel_status_byte_in[c*8 +: 8];
        cs_pos_nxt[c*`PIM_POS_W +: `PIM_POS_W] = pos[`PIM_POS_W-1:0];
        pos = pos + 1;
        if (eff_align) begin
          pos = pos + 1;
        end
      end
      img_nxt[pos*8 +: 8] = first_bytes[c*8 +: 8];
      img_nxt[(pos+1)*8 +: 8] = second_bytes[c*8 +: 8];
      pos = pos + 2;
    end
    words_nxt = pos[`PIM_CNT_W:1] + {{(`PIM_CNT_W-1){1'b0}}, pos[0]};
  end

  // --------------------------------------------------------------------------
  // Input image transfer
  // --------------------------------------------------------------------------
  assign send_word = in_img_r[send_idx_r[`PIM_IDX_W-1:0]*16 +: 16];
  assign fifo_push = (state_r == `PIM_ST_SEND) & fifo_wr_ready;

  always @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      state_r <= `PIM_ST_IDLE;
      in_img_r <= {IMG_BITS{1'b0}};
      words_r <= {`PIM_CNT_W{1'b0}};
      send_idx_r <= {`PIM_CNT_W{1'b0}};
      cs_pos_r <= {(NCH*`PIM_POS_W){1'b0}};
      incl_r <= {NCH{1'b0}};
    end else begin
      case (state_r)
        `PIM_ST_IDLE: begin
          cs_pos_r <= cs_pos_nxt;
          incl_r <= incl_nxt;
          words_r <= words_nxt;
          if (xfer_req_in) begin
            in_img_r <= img_nxt;
            send_idx_r <= {`PIM_CNT_W{1'b0}};
            state_r <= `PIM_ST_SEND;
          end
        end
        `PIM_ST_SEND: begin
          if (fifo_push) begin
            send_idx_r <= send_idx_r + 1'b1;
            if (send_idx_r == words_r - 1'b1) begin
              state_r <= `PIM_ST_IDLE;
            end
          end
        end
        default: begin
          state_r <= `PIM_ST_IDLE;
        end
      endcase
    end
  end

  // A stalled fieldbus fills the FIFO and then holds the sender in place.
  pim_fifo #(
    .WIDTH(`PIM_WORD_W),
    .DEPTH(FIFO_DEPTH),
    .AW(4)
  ) u_fifo (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .wr_data_in(send_word),
    .wr_valid_in(state_r == `PIM_ST_SEND),
    .wr_ready_out(fifo_wr_ready),
    .rd_data_out(in_word_out),
    .rd_valid_out(in_valid_out),
    .rd_ready_in(in_ready_in)
  );

  // --------------------------------------------------------------------------
  // Output image and configuration port
  // --------------------------------------------------------------------------
  // A configuration write in the same cycle as a fieldbus write is dropped
  // and flagged; retrying is left to the configuration tool.
  always @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      for (w = 0; w < `PIM_MAX_WORDS; w = w + 1) begin
        out_img_r[w] <= `PIM_ZERO_WORD;
      end
      cfg_out_refused_r <= 1'b0;
    end else begin
      cfg_out_refused_r <= cfg_out_wr_in & fb_out_wr_in;
      if (fb_out_wr_in) begin
        out_img_r[fb_out_idx_in] <= fb_out_word_in;
      end else if (cfg_out_wr_in) begin
        out_img_r[cfg_out_idx_in] <= cfg_out_word_in;
      end
    end
  end

  always @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      cfg_rd_data_r <= `PIM_ZERO_WORD;
    end else if (cfg_rd_img_in) begin
      cfg_rd_data_r <= out_img_r[cfg_rd_idx_in];
    end else begin
      cfg_rd_data_r <= in_img_r[cfg_rd_idx_in*16 +: 16];
    end
  end

  // --------------------------------------------------------------------------
  // Control byte extraction
  // --------------------------------------------------------------------------
  // Only the mapped control byte position is read, so pad bytes written by
  // the master never reach a channel.
  always @* begin
    ctrl_byte_nxt = {(NCH*8){1'b0}};
    for (k = 0; k < NCH; k = k + 1) begin
      if (incl_r[k]) begin
        if (cs_pos_r[k*`PIM_POS_W]) begin
          ctrl_byte_nxt[k*8 +: 8] = out_img_r[cs_pos_r[k*`PIM_POS_W+1 +: 3]][15:8];
        end else begin
          ctrl_byte_nxt[k*8 +: 8] = out_img_r[cs_pos_r[k*`PIM_POS_W+1 +: 3]][7:0];
        end
      end
    end
  end

  // A channel with no mapped control byte reports zero and no valid flag, so
  // parameter access through process data stays closed for it.
  always @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      ctrl_byte_r <= {(NCH*8){1'b0}};
      ctrl_valid_r <= {NCH{1'b0}};
    end else begin
      ctrl_byte_r <= ctrl_byte_nxt;
      ctrl_valid_r <= incl_r;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign xfer_busy_out = (state_r == `PIM_ST_SEND);
  assign img_words_out = words_r;
  assign cfg_out_refused_out = cfg_out_refused_r;
  assign cfg_rd_data_out = cfg_rd_data_r;
  assign channel_control_byte_out = ctrl_byte_r;
  assign ctrl_valid_out = ctrl_valid_r;

endmodule // process_image_byte_mapper
